// ---- shared/capture_pkg.sv ----
// Purpose: constants and types shared by the capture buffer control block
// Assumes: 32-bit apb register bus, one word per register
// Notes:   offsets are byte addresses
package capture_pkg;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0] CAPTURE_CONTROL_OFS = 8'h00;
   localparam logic [7:0] FIRST_START_OFS     = 8'h04;
   localparam logic [7:0] SECOND_START_OFS    = 8'h08;
   localparam logic [7:0] BUFFER_LENGTH_OFS   = 8'h0c;
   localparam logic [7:0] PROGRESS_OFS        = 8'h10;

   // ************************************************************
   // capture_control field positions
   // ************************************************************
   localparam int SOFT_RESET_BIT      = 31;
   localparam int LOOPBACK_SEL_BIT    = 30;
   localparam int STAY_AWAKE_BIT      = 29;
   localparam int CAPTURE_ON_BIT      = 28;
   localparam int FIRST_IRQ_EN_BIT    = 27;
   localparam int SECOND_IRQ_EN_BIT   = 26;
   localparam int BW_IRQ_EN_BIT       = 25;
   localparam int LOST_IRQ_EN_BIT     = 24;
   localparam int FIRST_ACK_BIT       = 23;
   localparam int SECOND_ACK_BIT      = 22;
   localparam int BW_ACK_BIT          = 21;
   localparam int LOST_ACK_BIT        = 20;
   localparam int FIRST_CURRENT_BIT   = 4;
   localparam int FIRST_FILLED_BIT    = 3;
   localparam int SECOND_FILLED_BIT   = 2;
   localparam int BW_FLAG_BIT         = 1;
   localparam int LOST_FLAG_BIT       = 0;

   // ************************************************************
   // reset values and sizes
   // ************************************************************
   localparam logic [31:0] ADDR_RESET      = 32'h0000_0000;
   localparam logic [31:0] SOFT_RESET_WORD = 32'h8000_0000;
   localparam logic [31:0] ALIGN_MASK      = 32'hffff_ffc0;
   localparam int          BURST_BYTES     = 64;

   // memory highway write request
   typedef struct packed {
      logic        valid;
      logic [31:0] addr;
   } mem_req_t;

   // control settings seen by the datapath
   typedef struct packed {
      logic loopback_select;
      logic stay_awake;
      logic capture_on;
   } ctl_t;

endpackage

// ---- core/audio_capture_buffer_control.sv ----
// Purpose: control/status and buffer switching of the audio capture unit
// Assumes: samples arrive as one-cycle strobes from the converter logic
// Notes:   one 64-byte burst request per burst of samples to memory
//
// Notes on behaviour
// - writing only bit 31 to control resets the unit; reads as zero
// - loopback select: 0 normal (reset), 1 diagnostic loopback
// - stay awake 0 joins global power down, 1 stays out
// - capture on makes unit capture and write memory; 0 inactive
// - four enables gate full, bandwidth and lost flags onto irq 11
// - buffer acknowledges clear full flags and irq; read zero
// - error acknowledges clear error flags and irq; read zero
// - current-buffer status is 1 for buffer one, 1 after reset
// - full flags reset 0; acknowledge rearms base and size
// - bandwidth error when sample arrives with burst still pending
// - lost flag on samples lost, cleared only by its acknowledge
// - any reset disables capture and selects buffer one
// - fill buffer one first, then alternate without gap
// - acknowledge drops irq contribution at the next edge
// - stay awake keeps writing in global power down and wakes processor
// - block power down bit also powers the unit down
// - errors halt sampling until buffer supplied or burst written
// - length counts samples: stereo pair or mono value is one
`timescale 1ns/10ps
module audio_capture_buffer_control
   import capture_pkg::*;
#(
   parameter int SAMPLE_BYTES_MAX = 4
) (
   // clock and reset
   input  wire logic        clk_sys_i,
   input  wire logic        sys_rst_i,
   // apb slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // sample stream from converter
   input  wire logic        sample_stb_i,
   input  wire logic        stereo_i,
   input  wire logic [2:0]  sample_bytes_i,
   // memory highway burst port
   output mem_req_t         mem_req_o,
   input  wire logic        mem_done_i,
   // power management
   input  wire logic        global_pd_i,
   input  wire logic        block_pd_i,
   output logic             powered_down_o,
   output logic             wake_o,
   output ctl_t             ctl_o,
   // interrupt request 11
   output logic             irq_o
);

   // ************************************************************
   // elaboration check
   // ************************************************************
   if (SAMPLE_BYTES_MAX < 1 || SAMPLE_BYTES_MAX > BURST_BYTES) begin : g_chk
      $error("sample size must fit one burst");
   end

   // ************************************************************
   // bus decode
   // ************************************************************
   logic        wr_en;
   logic        rd_en;
   logic        soft_rst;
   logic        unit_rst;
   logic        ctl_wr;
   logic [31:0] rd_word;
   logic        addr_ok;

   assign wr_en    = psel_i & penable_i & pwrite_i;
   assign rd_en    = psel_i & penable_i & ~pwrite_i;
   assign ctl_wr   = wr_en & (paddr_i == CAPTURE_CONTROL_OFS);
   assign soft_rst = ctl_wr & (pwdata_i == SOFT_RESET_WORD);
   // the reset word alone resets; any other control write is taken as fields
   // hardware or software reset
   assign unit_rst = sys_rst_i | soft_rst;
   // zero wait states: every access completes in its first access cycle
   assign pready_o = 1'b1;
   assign addr_ok  = (paddr_i == CAPTURE_CONTROL_OFS) |
                     (paddr_i == FIRST_START_OFS) |
                     (paddr_i == SECOND_START_OFS) |
                     (paddr_i == BUFFER_LENGTH_OFS) |
                     (paddr_i == PROGRESS_OFS);
   assign pslverr_o = psel_i & penable_i & ~addr_ok;

   // ************************************************************
   // control bits
   // ************************************************************
   logic loop_r;
   logic awake_r;
   logic cap_on_r;
   logic [3:0] irq_en_r;
   logic first_buffer_acknowledge;
   logic second_buffer_acknowledge;
   logic ack_bw;
   logic ack_lost;

   assign first_buffer_acknowledge     = ctl_wr & ~soft_rst & pwdata_i[FIRST_ACK_BIT];
   assign second_buffer_acknowledge     = ctl_wr & ~soft_rst & pwdata_i[SECOND_ACK_BIT];
   assign ack_bw   = ctl_wr & ~soft_rst & pwdata_i[BW_ACK_BIT];
   assign ack_lost = ctl_wr & ~soft_rst & pwdata_i[LOST_ACK_BIT];

   always_ff @(posedge clk_sys_i) begin
      if (unit_rst) begin
         loop_r   <= 1'b0;
         awake_r  <= 1'b0;
         cap_on_r <= 1'b0;
         irq_en_r <= 4'h0;
      end else if (ctl_wr) begin
         loop_r   <= pwdata_i[LOOPBACK_SEL_BIT];
         awake_r  <= pwdata_i[STAY_AWAKE_BIT];
         cap_on_r <= pwdata_i[CAPTURE_ON_BIT];
         irq_en_r <= pwdata_i[FIRST_IRQ_EN_BIT:LOST_IRQ_EN_BIT];
      end
   end

   // ************************************************************
   // buffer descriptors
   // ************************************************************
   logic [31:0] first_buffer_start_r;
   logic [31:0] second_buffer_start_r;
   logic [31:0] size_r;
   // base and length survive a soft reset; only a hard reset clears them
   // the low six bits are forced to zero so every burst stays aligned

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         first_buffer_start_r <= ADDR_RESET;
         second_buffer_start_r <= ADDR_RESET;
         size_r  <= ADDR_RESET;
      end else if (wr_en) begin
         if (paddr_i == FIRST_START_OFS) begin
            first_buffer_start_r <= pwdata_i & ALIGN_MASK;
         end
         if (paddr_i == SECOND_START_OFS) begin
            second_buffer_start_r <= pwdata_i & ALIGN_MASK;
         end
         if (paddr_i == BUFFER_LENGTH_OFS) begin
            size_r <= pwdata_i & ALIGN_MASK;
         end
      end
   end

   // ************************************************************
   // power state
   // ************************************************************
   logic pd;
   // stay awake overrides global power down
   assign pd = block_pd_i | (global_pd_i & ~awake_r);
   assign powered_down_o = pd;
   assign ctl_o = '{loopback_select: loop_r, stay_awake: awake_r,
                    capture_on: cap_on_r};

   // ************************************************************
   // capture sequencing
   // ************************************************************
   logic        cur1_r;
   logic        full1_r;
   logic        full2_r;
   logic        bw_r;
   logic        lost_r;
   logic [31:0] count_r;
   logic [6:0]  fill_r;
   logic        burst_rdy_r;
   logic        pend_r;
   logic [31:0] wptr_r;
   logic [31:0] burst_addr_r;
   logic        active;
   logic        take;
   logic        last;
   logic        cur_full;
   logic        halted_r;
   logic [6:0]  fill_nxt;

   // capture stops while powered down; registers and flags keep state
   assign active   = cap_on_r & ~pd;
   assign cur_full = cur1_r ? full1_r : full2_r;
   // halt while no buffer or burst backlog
   assign take     = active & sample_stb_i & ~cur_full &
                     ~(burst_rdy_r & pend_r);
   // a length of zero behaves as a length of one sample
   // one count per stereo pair or mono value
   assign last     = (count_r + 32'd1) >= size_r;
   // bytes taken in, doubled when a stereo pair arrives
   assign fill_nxt = fill_r + {4'h0, sample_bytes_i} +
                     (stereo_i ? {4'h0, sample_bytes_i} : 7'h00);

   always_ff @(posedge clk_sys_i) begin
      if (unit_rst) begin
         cur1_r  <= 1'b1;
         count_r <= 32'h0000_0000;
         wptr_r  <= ADDR_RESET;
         fill_r  <= 7'h00;
         halted_r <= 1'b1;
      end else if (take) begin
         if (halted_r) begin
            wptr_r <= first_buffer_start_r;
            halted_r <= 1'b0;
         end
         if (last) begin
            // next base is read at the swap, so software may refill until then
            // swap buffers without a gap
            cur1_r  <= ~cur1_r;
            count_r <= 32'h0000_0000;
         end else begin
            count_r <= count_r + 32'd1;
         end
         fill_r <= (fill_nxt >= 7'(BURST_BYTES)) ?
                   fill_nxt - 7'(BURST_BYTES) : fill_nxt;
         if (fill_nxt >= 7'(BURST_BYTES)) begin
            wptr_r <= last ? (cur1_r ? second_buffer_start_r : first_buffer_start_r)
                           : wptr_r + 32'(BURST_BYTES);
         end else if (last) begin
            wptr_r <= cur1_r ? second_buffer_start_r : first_buffer_start_r;
         end
      end
   end

   // burst handoff to the memory highway
   // take is held off while a burst waits, so a burst is never overwritten
   always_ff @(posedge clk_sys_i) begin
      if (unit_rst) begin
         burst_rdy_r  <= 1'b0;
         pend_r       <= 1'b0;
         burst_addr_r <= ADDR_RESET;
      end else begin
         if (mem_done_i) begin
            pend_r <= 1'b0;
         end
         if (take && fill_nxt >= 7'(BURST_BYTES)) begin
            burst_rdy_r  <= 1'b1;
            pend_r       <= 1'b1;
            burst_addr_r <= halted_r ? first_buffer_start_r : wptr_r;
         end else if (mem_done_i) begin
            burst_rdy_r <= 1'b0;
         end
      end
   end

   assign mem_req_o = '{valid: pend_r, addr: burst_addr_r};

   // ************************************************************
   // status flags: set beats clear
   // ************************************************************
   always_ff @(posedge clk_sys_i) begin
      if (unit_rst) begin
         full1_r <= 1'b0;
         full2_r <= 1'b0;
         bw_r    <= 1'b0;
         lost_r  <= 1'b0;
      end else begin
         if (take && last && cur1_r) begin
            full1_r <= 1'b1;
         end else if (first_buffer_acknowledge) begin
            full1_r <= 1'b0;
         end
         if (take && last && !cur1_r) begin
            full2_r <= 1'b1;
         end else if (second_buffer_acknowledge) begin
            full2_r <= 1'b0;
         end
         if (active && sample_stb_i && burst_rdy_r && pend_r) begin
            bw_r <= 1'b1;
         end else if (ack_bw) begin
            bw_r <= 1'b0;
         end
         // the sample is dropped while the current buffer is still full
         // lost sample, only its acknowledge clears
         if (active && sample_stb_i && cur_full) begin
            lost_r <= 1'b1;
         end else if (ack_lost) begin
            lost_r <= 1'b0;
         end
      end
   end

   // ************************************************************
   // interrupt and readback
   // ************************************************************
   // flags are registered, so an acknowledge drops the line one edge later
   // level irq from registered flags
   assign irq_o = (full1_r & irq_en_r[3]) | (full2_r & irq_en_r[2]) |
                  (bw_r & irq_en_r[1]) | (lost_r & irq_en_r[0]);
   assign wake_o = irq_o & awake_r;

   always_comb begin
      rd_word = 32'h0000_0000;
      case (paddr_i)
         CAPTURE_CONTROL_OFS: begin
            rd_word[LOOPBACK_SEL_BIT]  = loop_r;
            rd_word[STAY_AWAKE_BIT]    = awake_r;
            rd_word[CAPTURE_ON_BIT]    = cap_on_r;
            rd_word[FIRST_IRQ_EN_BIT:LOST_IRQ_EN_BIT] = irq_en_r;
            rd_word[FIRST_CURRENT_BIT] = cur1_r;
            rd_word[FIRST_FILLED_BIT]  = full1_r;
            rd_word[SECOND_FILLED_BIT] = full2_r;
            rd_word[BW_FLAG_BIT]       = bw_r;
            rd_word[LOST_FLAG_BIT]     = lost_r;
         end
         FIRST_START_OFS:   rd_word = first_buffer_start_r;
         SECOND_START_OFS:  rd_word = second_buffer_start_r;
         BUFFER_LENGTH_OFS: rd_word = size_r;
         PROGRESS_OFS:      rd_word = count_r;
         default:           rd_word = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i) begin
         prdata_o <= 32'h0000_0000;
      // read data captured in setup, standing through the access phase
      end else if (psel_i && !penable_i && !pwrite_i) begin
         prdata_o <= rd_word;
      end
   end

endmodule

// ---- verification/capture_checker_properties.sv ----
// Purpose: port checks of the capture buffer control block
// Assumes: control writes land in one apb access cycle
// Notes:   bound to every instance of the block
`timescale 1ns/10ps
module capture_checker
   import capture_pkg::*;
#(parameter int SAMPLE_BYTES_MAX = 4) (
   input wire logic        clk_sys_i,
   input wire logic        sys_rst_i,
   input wire logic        psel_i,
   input wire logic        penable_i,
   input wire logic        pwrite_i,
   input wire logic [7:0]  paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic        sample_stb_i,
   input wire mem_req_t    mem_req_o,
   input wire logic        mem_done_i,
   input wire logic        global_pd_i,
   input wire logic        block_pd_i,
   input wire logic        powered_down_o,
   input wire logic        wake_o,
   input wire ctl_t        ctl_o,
   input wire logic        irq_o
);
   logic [31:0] wd_r;
   always_ff @(posedge clk_sys_i) begin
      wd_r <= pwdata_i;
   end
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (sys_rst_i);
   sequence s_ctl_wr;
      psel_i && penable_i && pwrite_i && paddr_i == CAPTURE_CONTROL_OFS;
   endsequence
   sequence s_soft;
      s_ctl_wr ##0 pwdata_i == SOFT_RESET_WORD;
   endsequence
   a_reset_clear: assert property (
      $fell(sys_rst_i) |-> ctl_o == '0 && !irq_o && !mem_req_o.valid)
      else $error("reset left outputs set");
   a_soft_reset: assert property (
      s_soft |=> ctl_o == '0 && !irq_o && !mem_req_o.valid)
      else $error("soft reset left outputs set");
   a_ctl_fields: assert property (
      s_ctl_wr ##0 pwdata_i != SOFT_RESET_WORD
      |=> ctl_o == {wd_r[30], wd_r[29], wd_r[28]})
      else $error("control fields not taken");
   a_ack_clears: assert property (
      s_ctl_wr ##0 (pwdata_i[27:24] & ~pwdata_i[23:20]) == 4'h0
      ##0 !sample_stb_i |=> !irq_o)
      else $error("irq kept after ack");
   a_wake_rule: assert property (
      wake_o == (irq_o && ctl_o.stay_awake))
      else $error("wake mismatch");
   a_power_down: assert property (
      powered_down_o == (block_pd_i || global_pd_i && !ctl_o.stay_awake))
      else $error("power down mismatch");
   a_burst_hold: assert property (
      mem_req_o.valid && !mem_done_i && !(psel_i && pwrite_i)
      |=> mem_req_o.valid && $stable(mem_req_o.addr))
      else $error("burst request dropped early");
   a_burst_align: assert property (
      mem_req_o.valid |-> mem_req_o.addr[5:0] == 6'h00)
      else $error("burst address not aligned");
endmodule
bind audio_capture_buffer_control capture_checker #(
   .SAMPLE_BYTES_MAX(SAMPLE_BYTES_MAX)
) chk_u (
   .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
   .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
   .pwdata_i(pwdata_i), .sample_stb_i(sample_stb_i),
   .mem_req_o(mem_req_o), .mem_done_i(mem_done_i),
   .global_pd_i(global_pd_i), .block_pd_i(block_pd_i),
   .powered_down_o(powered_down_o), .wake_o(wake_o), .ctl_o(ctl_o),
   .irq_o(irq_o)
);

// ---- verification/highway_model.sv ----
// Purpose: memory highway answering 64-byte burst requests
// Assumes: a request stays up until done is seen
// Notes:   stall_i holds the answer back
`timescale 1ns/10ps
module highway_model
   import capture_pkg::*;
(
   input  wire logic     clk_sys_i,
   input  wire logic     sys_rst_i,
   input  wire mem_req_t mem_req_i,
   input  wire logic     stall_i,
   output logic          mem_done_o
);
   logic [1:0] wait_r;
   always_ff @(posedge clk_sys_i) begin
      if (sys_rst_i || !mem_req_i.valid || mem_done_o) begin
         wait_r     <= 2'h0;
         mem_done_o <= 1'b0;
      end else if (!stall_i && wait_r == 2'h2) begin
         mem_done_o <= 1'b1;
      end else if (!stall_i) begin
         wait_r <= wait_r + 2'h1;
      end
   end
endmodule

// ---- verification/tb_audio_capture_buffer_control.sv ----
// Purpose: self-checking bench of the capture buffer control block
// Assumes: mostly mono one-byte samples, buffers of 64 samples
// Notes:   the highway model stalls on request
`timescale 1ns/10ps
module tb_audio_capture_buffer_control;
   import capture_pkg::*;
   localparam logic [7:0] CTL_A = CAPTURE_CONTROL_OFS;
   logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0;
   logic        pwr = 1'b0, stb = 1'b0, gpd = 1'b0, bpd = 1'b0;
   logic        stall = 1'b0, prdy, perr, done, pdn, wake, irq, err;
   logic        stereo = 1'b0;
   logic [2:0]  sbytes = 3'h1;
   logic [7:0]  pa = 8'h00;
   logic [31:0] pwd = 32'h0, prd, rdv;
   mem_req_t    req;
   ctl_t        ctl;
   int          miscompares = 0;
   int          checked = 0;
   always #25 clk = ~clk;
   audio_capture_buffer_control dut_u (
      .clk_sys_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd),
      .pready_o(prdy), .pslverr_o(perr), .sample_stb_i(stb),
      .stereo_i(stereo), .sample_bytes_i(sbytes), .mem_req_o(req),
      .mem_done_i(done), .global_pd_i(gpd), .block_pd_i(bpd),
      .powered_down_o(pdn), .wake_o(wake), .ctl_o(ctl), .irq_o(irq));
   highway_model hw_u (.clk_sys_i(clk), .sys_rst_i(rst), .mem_req_i(req),
      .stall_i(stall), .mem_done_o(done));
   task automatic give_verdict;
      if (miscompares == 0 && checked > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] %0t seen %h want %h", $time, seen, exp);
      end
   endtask
   task automatic hang;
      miscompares++;
      give_verdict();
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      int n;
      psel <= 1'b1;
      pwr <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do @(posedge clk); while (prdy !== 1'b1 && ++n < 16);
      if (n >= 16) hang();
      rdv = prd;
      err = perr;
      psel <= 1'b0;
      pen <= 1'b0;
      @(posedge clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdv, e);
   endtask
   task automatic send(input int n);
      repeat (n) begin
         stb <= 1'b1;
         @(posedge clk);
         stb <= 1'b0;
         // spacing lets the highway finish a burst before the next sample
         repeat (5) @(posedge clk);
      end
   endtask
   task automatic wait_req(input logic v);
      int n;
      for (n = 0; req.valid !== v && n < 50; n++) @(posedge clk);
      if (n >= 50) hang();
   endtask
   task automatic pd_loop(input logic s);
      for (int i = 0; i < 4; i++) begin
         gpd <= i[0];
         bpd <= i[1];
         @(posedge clk);
         chk(pdn, i[1] | (i[0] & ~s));
      end
      gpd <= 1'b0;
      bpd <= 1'b0;
   endtask
   task automatic t_regs;
      rd(CTL_A, 32'h0000_0010);
      rd(BUFFER_LENGTH_OFS, 32'h0);
      chk(ctl, 3'h0);
      apb(1'b1, CTL_A, 32'h7ff0_0000);
      rd(CTL_A, 32'h7f00_0010);
      chk(ctl, 3'h7);
      apb(1'b1, CTL_A, SOFT_RESET_WORD);
      rd(CTL_A, 32'h0000_0010);
      rd(8'h14, 32'h0);
      chk(err, 1'b1);
      apb(1'b1, FIRST_START_OFS, 32'h1234_567f);
      rd(FIRST_START_OFS, 32'h1234_5640);
   endtask
   task automatic t_fill;
      apb(1'b1, CTL_A, SOFT_RESET_WORD);
      apb(1'b1, FIRST_START_OFS, 32'h100);
      apb(1'b1, SECOND_START_OFS, 32'h200);
      apb(1'b1, BUFFER_LENGTH_OFS, 32'h40);
      repeat (5) @(posedge clk);
      apb(1'b1, CTL_A, 32'h1f00_0000);
      stall <= 1'b1;
      send(64);
      wait_req(1'b1);
      chk(req.addr, 32'h100);
      chk(irq, 1'b1);
      rd(CTL_A, 32'h1f00_0008);
      stall <= 1'b0;
      wait_req(1'b0);
      apb(1'b1, CTL_A, 32'h1f80_0000);
      rd(CTL_A, 32'h1f00_0000);
      chk(irq, 1'b0);
   endtask
   task automatic t_overrun;
      send(64);
      rd(CTL_A, 32'h1f00_0014);
      send(65);
      rd(CTL_A, 32'h1f00_000d);
      apb(1'b1, CTL_A, 32'h1fc0_0000);
      rd(CTL_A, 32'h1f00_0001);
      chk(irq, 1'b1);
      apb(1'b1, CTL_A, 32'h1ff0_0000);
      rd(CTL_A, 32'h1f00_0000);
   endtask
   task automatic t_bw_power;
      stall <= 1'b1;
      send(66);
      rd(CTL_A, 32'h1f00_0016);
      stall <= 1'b0;
      wait_req(1'b0);
      apb(1'b1, CTL_A, 32'h3f00_0000);
      chk(wake, 1'b1);
      pd_loop(1'b1);
      apb(1'b1, CTL_A, 32'h1f00_0000);
      chk(wake, 1'b0);
      pd_loop(1'b0);
      apb(1'b1, CTL_A, 32'h1f60_0000);
      rd(CTL_A, 32'h1f00_0010);
   endtask
   task automatic t_stereo;
      stall <= 1'b1;
      stereo <= 1'b1;
      sbytes <= 3'h2;
      send(16);
      wait_req(1'b1);
      chk(req.addr, 32'h100);
      rd(PROGRESS_OFS, 32'h10);
      stall <= 1'b0;
      stereo <= 1'b0;
      sbytes <= 3'h1;
      wait_req(1'b0);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_regs();
      t_fill();
      t_overrun();
      t_bw_power();
      t_stereo();
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk);
      hang();
   end
endmodule
